// ### core/t1_esf_pkg.sv
// Constants and carriers for the extended superframe transmit framer
package t1_esf_pkg;
   localparam int          BITS_PER_FRAME   = 193;
   localparam int          FRAMES_PER_SUPER = 24;
   localparam logic [7:0]  BIT_COUNT_LAST   = 8'hC0;
   localparam logic [7:0]  BIT_COUNT_RESET  = 8'h00;
   localparam logic [4:0]  FRAME_COUNT_RESET = 5'h00;
   localparam logic [4:0]  FRAME_COUNT_LAST = 5'h1F;
   localparam logic [5:0]  PATTERN_RESET    = 6'h0B;
   localparam logic [8:0]  SHIFT_FLAG_ONLY  = 9'h100;
   localparam logic [2:0]  LOW3_ALL_ONES    = 3'h7;
   localparam logic [2:0]  LOW3_ZERO        = 3'h0;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } byte_slot_type;

   typedef struct packed {
      logic sig_a;
      logic sig_b;
      logic sig_c;
      logic sig_d;
   } robbed_bits_type;
endpackage : t1_esf_pkg

// ### core/t1_extended_superframe_tx.sv
// Extended superframe T1 serial transmit framer
// Functional notes
// - Reset clears and aligns bit counter and frame counter.
// - Latched hold request keeps counters in reset and suspends sending.
// - First frame end sends link bit and loads pattern register.
// - Bit counter is 8 bits, cleared after 193 states; decoder marks end.
// - Frame end pulse enables frame counter once per frame.
// - Data shift register stalls one clock during frame end.
// - 5-bit frame counter skips two states after low bits all ones.
// - Each frame sends 24 channel bytes after the framing bit.
// - Shift register is 9 bits; flag bit 8 is set on load and is lost at the first shift.
// - Byte request answered by data plus acknowledge; loads latch, clears request.
// - Latched byte moves in after previous finished, unless flagged all zeros.
// - All-zero byte raises external zero substitution signal.
// - Shift register loads eight bits in parallel, shifts one per enable.
// - Pattern bits held in 6-bit shift register, one per pattern frame.
// - Link, check and signaling registers request one frame before use.
// - External framing select sends outside framing bit at frame end.
// - Signaling register requests and captures inputs on acknowledge.
// - Frames 6,12,18,24 replace each channel LSB with A,B,C,D bit.
// - Pattern bit in frames 4,8..24; check bit in frames 2,6..22.
// - Otherwise frame number LSB selects the link bit.
// - Bit counter low three bits time data and signaling; link, check and signaling requests rise at bit count 1.
// - Channel timing strobe output lets outside logic track frames.
// - Pattern sequence across six pattern frames is 001011.
// - Link bit occupies framing position of odd frames from frame 1.
// - Frame is 24 eight-bit channels plus one framing bit.
module t1_extended_superframe_tx (
   input  wire logic                         clk,
   input  wire logic                         reset,
   input  wire logic                         hold_request_in,
   output logic                              hold_acknowledge_out,
   input  wire logic [7:0]                   channel_data_in,
   output logic                              byte_request,
   input  wire logic                         byte_acknowledge,
   input  wire logic                         external_framing_select,
   input  wire logic                         pattern_bit_input,
   input  wire logic                         link_bit_input,
   output logic                              link_request,
   input  wire logic                         link_acknowledge,
   input  wire logic                         check_bit_input,
   output logic                              check_request,
   input  wire logic                         check_acknowledge,
   input  wire t1_esf_pkg::robbed_bits_type  robbed_bit_inputs,
   output logic                              signaling_request,
   input  wire logic                         signaling_acknowledge,
   output logic                              serial_out,
   output logic                              zero_substitute,
   output logic                              channel_timing_strobe,
   output logic [7:0]                        bit_position_count,
   output logic [4:0]                        frame_number_count
);
   logic                         hold_s1_r;
   logic                         hold_s2_r;
   logic                         hold_r;
   logic [7:0]                   bit_r;
   logic [4:0]                   frame_r;
   logic                         frame_end;
   logic                         first_r;
   logic [8:0]                   shift_r;
   t1_esf_pkg::byte_slot_type    latch_r;
   logic                         zero_flag_r;
   logic [5:0]                   pattern_r;
   logic                         link_r;
   logic                         check_r;
   logic                         ext_r;
   t1_esf_pkg::robbed_bits_type  sig_r;
   logic                         shift_en;
   logic                         load_en;
   logic                         out_nxt;
   logic [4:0]                   frame_nxt;
   logic [4:0]                   frame_num;

   // Frame number 1..24 from counter code
   function automatic logic [4:0] frame_of(input logic [4:0] code);
      frame_of = 5'(code[4:3] * 6 + code[2:0] - 1);
   endfunction : frame_of

   // Low three bits of the bit counter at zero
   function automatic logic low3_zero(input logic [7:0] count);
      low3_zero = count[2:0] == t1_esf_pkg::LOW3_ZERO;
   endfunction : low3_zero

   // Input synchronisers and held request
   always_ff @(posedge clk) begin
      if (reset) begin
         hold_s1_r <= 1'b0;
         hold_s2_r <= 1'b0;
         hold_r    <= 1'b0;
      end else begin
         hold_s1_r <= hold_request_in;
         hold_s2_r <= hold_s1_r;
         hold_r    <= hold_s2_r;
      end
   end

   assign hold_acknowledge_out = hold_r && bit_r == t1_esf_pkg::BIT_COUNT_RESET;

   assign frame_end = bit_r == t1_esf_pkg::BIT_COUNT_LAST;
   assign frame_num = frame_of(frame_r);

   // Bit counter, modulo 193
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         bit_r <= t1_esf_pkg::BIT_COUNT_RESET;
      end else if (frame_end) begin
         bit_r <= t1_esf_pkg::BIT_COUNT_RESET;
      end else begin
         bit_r <= bit_r + 8'h01;
      end
   end

   // Frame counter next state with held bit 1
   always_comb begin
      frame_nxt = frame_r + 5'h01;
      if (frame_r[2:0] == t1_esf_pkg::LOW3_ALL_ONES) begin
         frame_nxt[1] = 1'b1;
      end
      if (frame_r == t1_esf_pkg::FRAME_COUNT_LAST) begin
         frame_nxt = 5'h02;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         frame_r <= t1_esf_pkg::FRAME_COUNT_RESET;
         first_r <= 1'b1;
      end else if (frame_end) begin
         first_r <= 1'b0;
         frame_r <= first_r ? 5'h02 : frame_nxt;
      end
   end

   // Frame number code 00010 is frame 1 after the first pulse
   assign shift_en  = !frame_end && !hold_r;
   assign load_en   = shift_en && low3_zero(bit_r);

   // Byte request, raised whenever the input latch is empty
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         byte_request <= 1'b0;
      end else if (byte_acknowledge && byte_request) begin
         byte_request <= 1'b0;
      end else if (!latch_r.valid && !byte_request) begin
         byte_request <= 1'b1;
      end
   end

   // Input latch
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         latch_r <= '0;
      end else if (byte_acknowledge && byte_request) begin
         latch_r.valid <= 1'b1;
         latch_r.data  <= channel_data_in;
      end else if (load_en && latch_r.valid) begin
         latch_r.valid <= 1'b0;
      end
   end

   // All-zero marker of the latched byte
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         zero_flag_r <= 1'b0;
      end else if (byte_acknowledge && byte_request) begin
         zero_flag_r <= channel_data_in == 8'h00;
      end
   end

   // Nine-bit data shift register
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         shift_r <= t1_esf_pkg::SHIFT_FLAG_ONLY;
      end else if (load_en) begin
         if (latch_r.valid && !zero_flag_r) begin
            shift_r <= {1'b1, latch_r.data};
         end else begin
            shift_r <= t1_esf_pkg::SHIFT_FLAG_ONLY;
         end
      end else if (shift_en) begin
         shift_r <= {shift_r[7:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         zero_substitute <= 1'b0;
      end else if (load_en) begin
         zero_substitute <= latch_r.valid && zero_flag_r;
      end
   end

   // Pattern register, rotated after each pattern frame
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         pattern_r <= t1_esf_pkg::PATTERN_RESET;
      end else if (frame_end) begin
         if (first_r) begin
            pattern_r <= t1_esf_pkg::PATTERN_RESET;
         end else if (frame_num[1:0] == 2'b00) begin
            pattern_r <= {pattern_r[4:0], pattern_r[5]};
         end
      end
   end

   // Link bit fetched during the frame before use; a new request wins
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         link_r       <= 1'b0;
         link_request <= 1'b0;
      end else begin
         if (link_acknowledge && link_request) begin
            link_r       <= link_bit_input;
            link_request <= 1'b0;
         end
         if (bit_r == 8'h01) begin
            link_request <= 1'b1;
         end
      end
   end

   // Check bit fetched during the frame before use
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         check_r       <= 1'b0;
         check_request <= 1'b0;
      end else begin
         if (check_acknowledge && check_request) begin
            check_r       <= check_bit_input;
            check_request <= 1'b0;
         end
         if (bit_r == 8'h01) begin
            check_request <= 1'b1;
         end
      end
   end

   // Signaling bits captured on acknowledge
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         sig_r             <= '0;
         signaling_request <= 1'b0;
      end else begin
         if (signaling_acknowledge && signaling_request) begin
            sig_r             <= robbed_bit_inputs;
            signaling_request <= 1'b0;
         end
         if (bit_r == 8'h01) begin
            signaling_request <= 1'b1;
         end
      end
   end

   // Externally supplied framing bit
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         ext_r <= 1'b0;
      end else begin
         ext_r <= pattern_bit_input;
      end
   end

   // Bit-select multiplexer
   always_comb begin
      out_nxt = shift_r[7];
      if (frame_end) begin
         if (external_framing_select) begin
            out_nxt = ext_r;
         end else if (first_r || frame_num[0]) begin
            out_nxt = link_r;
         end else if (!frame_num[1]) begin
            out_nxt = pattern_r[5];
         end else begin
            out_nxt = check_r;
         end
      end else if (low3_zero(bit_r)) begin
         case (frame_num)
            5'd6:    out_nxt = sig_r.sig_a;
            5'd12:   out_nxt = sig_r.sig_b;
            5'd18:   out_nxt = sig_r.sig_c;
            5'd24:   out_nxt = sig_r.sig_d;
            default: out_nxt = shift_r[7];
         endcase
      end
   end

   // Registered serial bit
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         serial_out <= 1'b0;
      end else begin
         serial_out <= out_nxt;
      end
   end

   // One-cycle strobe after each frame end
   always_ff @(posedge clk) begin
      if (reset || hold_r) begin
         channel_timing_strobe <= 1'b0;
      end else begin
         channel_timing_strobe <= frame_end;
      end
   end

   assign bit_position_count = bit_r;
   assign frame_number_count = frame_r;
endmodule : t1_extended_superframe_tx

// ### dv/t1_esf_monitor.sv
// Checker of counter, strobe, hold and handshake timing of the framer
module t1_esf_monitor (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       hold_request_in,
   input wire logic       hold_acknowledge_out,
   input wire logic       byte_request,
   input wire logic       byte_acknowledge,
   input wire logic       link_request,
   input wire logic       link_acknowledge,
   input wire logic       channel_timing_strobe,
   input wire logic [7:0] bit_position_count,
   input wire logic [4:0] frame_number_count
);
   default clocking mon_cb @(posedge clk); endclocking
   default disable iff (reset);
   a_count_step: assert property (bit_position_count != 8'hC0 |=>
      bit_position_count == $past(bit_position_count) + 8'h01 || bit_position_count == 8'h00)
      else $error("bit count step wrong");
   a_count_wrap: assert property (bit_position_count == 8'hC0 |=> bit_position_count == 8'h00)
      else $error("bit count did not wrap");
   a_frame_still: assert property (disable iff (reset || hold_request_in)
      bit_position_count != 8'hC0 |=> $stable(frame_number_count))
      else $error("frame count moved mid frame");
   a_frame_skip: assert property (disable iff (reset || hold_request_in)
      bit_position_count == 8'hC0 && frame_number_count[2:0] == 3'h7
      |=> frame_number_count[2:0] == 3'h2) else $error("frame skip wrong");
   a_first_frame: assert property (disable iff (reset || hold_request_in)
      bit_position_count == 8'hC0 && frame_number_count == 5'h00
      |=> frame_number_count == 5'h02) else $error("first frame code wrong");
   a_strobe_pulse: assert property (bit_position_count == 8'hC0
      |=> channel_timing_strobe ##1 !channel_timing_strobe) else $error("strobe wrong");
   a_byte_clear: assert property (byte_request && byte_acknowledge |=> !byte_request)
      else $error("byte request stayed");
   a_link_clear: assert property (link_request && link_acknowledge |=> !link_request)
      else $error("link request stayed");
   a_hold_counts: assert property (hold_acknowledge_out
      |-> bit_position_count == 8'h00 && frame_number_count == 5'h00)
      else $error("hold with counters running");
endmodule : t1_esf_monitor

bind t1_extended_superframe_tx t1_esf_monitor mon (.clk(clk), .reset(reset),
   .hold_request_in(hold_request_in), .hold_acknowledge_out(hold_acknowledge_out),
   .byte_request(byte_request), .byte_acknowledge(byte_acknowledge),
   .link_request(link_request), .link_acknowledge(link_acknowledge),
   .channel_timing_strobe(channel_timing_strobe),
   .bit_position_count(bit_position_count), .frame_number_count(frame_number_count));

// ### dv/t1_esf_responder.sv
// Far-side responder for one request and acknowledge pair
module t1_esf_responder #(
   parameter int W   = 1,
   parameter int LAG = 0
) (
   input  wire logic         clk,
   input  wire logic         req,
   input  wire logic [W-1:0] value,
   output logic              ack,
   output logic [W-1:0]      data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ack = 1'b0;
      data = ~value;
      forever begin
         @(posedge clk);
         #1;
         if (req === 1'b1) begin
            repeat (LAG) @(posedge clk);
            if (LAG > 0) #1;
            ack = 1'b1;
            data = value;
            @(posedge clk);
            #1 ack = 1'b0;
            data = ~value;
         end
      end
   end
endmodule : t1_esf_responder

// ### dv/t1_extended_superframe_tx_tb.sv
// Self-checking bench of the T1 transmit framer
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("CHECK FAILED %0t %s", $time, m); end end
module t1_extended_superframe_tx_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, reset = 1'b1, hold_request_in = 1'b0, external_framing_select = 1'b0;
   logic [7:0] byte_val = 8'hA5, channel_data_in, bit_position_count;
   logic link_val = 1'b0, check_val = 1'b0, byte_request, byte_acknowledge, link_request;
   logic [3:0] sig_val = 4'hF;
   logic pattern_val = 1'b0;
   logic link_acknowledge, link_bit_input, check_request, check_acknowledge, check_bit_input;
   logic signaling_request, signaling_acknowledge, serial_out, zero_substitute;
   logic channel_timing_strobe, hold_acknowledge_out;
   logic [4:0] frame_number_count, exp;
   t1_esf_pkg::robbed_bits_type robbed_bit_inputs;
   int fail_count = 0, total_checks = 0, n, ones, zs;
   logic [3:0] mode_list [5] = '{4'h2, 4'hA, 4'h6, 4'h0, 4'h3};
   always #2 clk = ~clk;
   t1_esf_responder #(.W(8), .LAG(3)) byte_side (.clk(clk), .req(byte_request),
      .value(byte_val), .ack(byte_acknowledge), .data(channel_data_in));
   t1_esf_responder #(.W(1), .LAG(0)) link_side (.clk(clk), .req(link_request),
      .value(link_val), .ack(link_acknowledge), .data(link_bit_input));
   t1_esf_responder #(.W(1), .LAG(2)) check_side (.clk(clk), .req(check_request),
      .value(check_val), .ack(check_acknowledge), .data(check_bit_input));
   t1_esf_responder #(.W(4), .LAG(1)) sig_side (.clk(clk), .req(signaling_request),
      .value(sig_val), .ack(signaling_acknowledge), .data(robbed_bit_inputs));
   t1_extended_superframe_tx uut (.clk(clk), .reset(reset), .hold_request_in(hold_request_in),
      .hold_acknowledge_out(hold_acknowledge_out), .channel_data_in(channel_data_in),
      .byte_request(byte_request), .byte_acknowledge(byte_acknowledge),
      .external_framing_select(external_framing_select), .pattern_bit_input(pattern_val),
      .link_bit_input(link_bit_input), .link_request(link_request),
      .link_acknowledge(link_acknowledge), .check_bit_input(check_bit_input),
      .check_request(check_request), .check_acknowledge(check_acknowledge),
      .robbed_bit_inputs(robbed_bit_inputs), .signaling_request(signaling_request),
      .signaling_acknowledge(signaling_acknowledge), .serial_out(serial_out),
      .zero_substitute(zero_substitute), .channel_timing_strobe(channel_timing_strobe),
      .bit_position_count(bit_position_count), .frame_number_count(frame_number_count));
   // Returns just after the edge that ends a frame; n is cycles waited
   task automatic frame_end;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (bit_position_count !== t1_esf_pkg::BIT_COUNT_LAST && n < 400);
      @(posedge clk);
      #1;
      n++;
   endtask : frame_end
   task automatic test_frames;
      frame_end();
      exp = 5'h02;
      `CHK(frame_number_count, exp, "first frame code")
      for (int i = 0; i < 24; i++) begin
         exp = (exp + 5'h01) | ((exp[2:0] == 3'h7) ? 5'h02 : 5'h00);
         frame_end();
         `CHK(n, 193, "frame length")
         `CHK(frame_number_count, exp, "frame code sequence")
      end
      $display("test frames done");
   endtask : test_frames
   task automatic test_hold;
      hold_request_in = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      `CHK({hold_acknowledge_out, bit_position_count}, 9'h100, "hold not taken")
      `CHK(hold_acknowledge_out, 1'b1, "hold acknowledge missing")
      repeat (300) @(posedge clk);
      #1;
      `CHK({link_request, check_request, signaling_request}, 3'h0, "request in hold")
      hold_request_in = 1'b0;
      $display("test hold done");
   endtask : test_hold
   // Counts ones over one superframe after a superframe of settling
   task automatic test_ones(input logic [3:0] m);
      {link_val, check_val, sig_val[0], external_framing_select} = m;
      sig_val = {4{m[1]}};
      pattern_val = m[1];
      repeat (4632) @(posedge clk);
      ones = 0;
      zs = 0;
      repeat (4632) begin
         @(negedge clk);
         ones += serial_out;
         zs += zero_substitute;
      end
      #1;
      `CHK(ones, 2304 + (m[0] ? 24 * m[1] : 3 + 12 * m[3] + 6 * m[2]) - (m[1] ? 0 : 96), "ones")
      `CHK(zs, 0, "zero flag on live data")
      $display("test ones %h done", m);
   endtask : test_ones
   task automatic test_zero;
      byte_val = 8'h00;
      zs = 0;
      repeat (400) begin
         @(negedge clk);
         zs += zero_substitute;
      end
      #1;
      `CHK(zs != 0, 1'b1, "no zero flag")
      byte_val = 8'hA5;
      $display("test zero done");
   endtask : test_zero
   task automatic end_of_test;
      $display("checks %0d failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #300000;
      fail_count++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      #1 reset = 1'b0;
      test_frames();
      test_hold();
      test_frames();
      foreach (mode_list[i]) test_ones(mode_list[i]);
      test_zero();
      end_of_test();
   end
endmodule : t1_extended_superframe_tx_tb
